// ===== core/uep_ctrl.sv
// Purpose: Host-side pin sequencer for a byte-wide UV EPROM array.
// Assumes: Board buffers turn vpp_prog and id_raise into supply levels.
// Notes:   One command at a time; every device idles in standby.
// Operation
// - Program: supply up, select, strobe low, gate high
// - Parallel parts share all but select
// - Verify with gate low, strobe high, supply up
// - Identifier: trigger raised, select, gate low
// - Other address lines low; toggle byte select
// - Decode select per part; shared read gate
module uep_ctrl #(
  parameter int NUM_DEV    = 4,
  parameter int PULSE_CYC  = uep_pkg::PULSE_CYC
) (
  input  wire logic                     i_clk,
  input  wire logic                     i_rst_b,
  input  wire logic                     i_cmd_valid,
  input  wire uep_pkg::uep_cmd_t        i_cmd,
  input  wire logic [$clog2(NUM_DEV)-1:0] i_cmd_dev,
  output logic                          o_cmd_ready,
  output logic                          o_rsp_valid,
  output uep_pkg::uep_rsp_t             o_rsp,
  output uep_pkg::uep_pins_t            o_pins,
  output logic [NUM_DEV-1:0]            o_dev_select_n,
  input  wire logic [uep_pkg::DATA_W-1:0] i_data_pins
);

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_SETUP,
    ST_STROBE,
    ST_ACCESS,
    ST_HOLD,
    ST_FLOAT
  } uep_state_t;

  localparam int TW       = uep_pkg::TMR_W;
  localparam int GATE_CYC = uep_pkg::ACC_CYC + uep_pkg::SYNC_CYC;

  uep_state_t                    state_q;
  uep_pkg::uep_cmd_t             cmd_q;
  uep_pkg::uep_pins_t            pins_q;
  logic [NUM_DEV-1:0]            sel_n_q;
  uep_pkg::uep_rsp_t             rsp_q;
  logic                          rsp_valid_q;
  logic [uep_pkg::DATA_W-1:0]    sync1_q;
  logic [uep_pkg::DATA_W-1:0]    sync2_q;
  logic                          tmr_load;
  logic [TW-1:0]                 tmr_count;
  logic                          tmr_done;
  logic                          take;

  // Phase length in cycles to timer load value
  function automatic logic [TW-1:0] phase(input int cyc);
    phase = TW'(cyc - 1);
  endfunction : phase

  // index address; identifier keeps only byte select
  function automatic logic [uep_pkg::ADDR_W-1:0] pin_addr(input uep_pkg::uep_cmd_t c);
    pin_addr = c.addr;
    if (c.op == uep_pkg::OP_IDENT) begin
      pin_addr = '0;
      pin_addr[uep_pkg::ID_SEL_BIT] = c.addr[uep_pkg::ID_SEL_BIT];
    end
  endfunction : pin_addr

  assign take        = (state_q == ST_IDLE) && i_cmd_valid;
  assign o_cmd_ready = (state_q == ST_IDLE);
  assign o_pins      = pins_q;
  assign o_dev_select_n = sel_n_q;
  assign o_rsp       = rsp_q;
  assign o_rsp_valid = rsp_valid_q;

  // Pins from outside pass two flops before use
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      sync1_q <= '0;
      sync2_q <= '0;
    end else begin
      sync1_q <= i_data_pins;
      sync2_q <= sync1_q;
    end
  end

  uep_timer #(
    .W       (TW)
  ) u_timer (
    .i_clk   (i_clk),
    .i_rst_b (i_rst_b),
    .i_load  (tmr_load),
    .i_count (tmr_count),
    .o_done  (tmr_done)
  );

  always_comb begin
    tmr_load  = 1'b0;
    tmr_count = '0;
    case (state_q)
      ST_IDLE: begin
        tmr_load  = take;
        tmr_count = phase(uep_pkg::SETUP_CYC);
      end
      ST_SETUP: begin
        tmr_load  = tmr_done;
        tmr_count = (cmd_q.op == uep_pkg::OP_PROGRAM) ? phase(PULSE_CYC)
                                                      : phase(GATE_CYC);
      end
      ST_STROBE: begin
        tmr_load  = tmr_done;
        tmr_count = phase(uep_pkg::HOLD_CYC);
      end
      ST_ACCESS: begin
        tmr_load  = tmr_done;
        tmr_count = phase(uep_pkg::FLOAT_CYC);
      end
      default: begin
        tmr_load  = 1'b0;
        tmr_count = '0;
      end
    endcase
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state_q <= ST_IDLE;
      cmd_q   <= '0;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (take) begin
            cmd_q   <= i_cmd;
            state_q <= ST_SETUP;
          end
        end
        ST_SETUP: begin
          if (tmr_done) begin
            state_q <= (cmd_q.op == uep_pkg::OP_PROGRAM) ? ST_STROBE : ST_ACCESS;
          end
        end
        ST_STROBE: if (tmr_done) state_q <= ST_HOLD;
        ST_ACCESS: if (tmr_done) state_q <= ST_FLOAT;
        ST_HOLD:   if (tmr_done) state_q <= ST_IDLE;
        ST_FLOAT:  if (tmr_done) state_q <= ST_IDLE;
        default:   state_q <= ST_IDLE;
      endcase
    end
  end

  // Pin levels; every part rests in standby with gate high
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      pins_q.addr             <= '0;
      pins_q.out_gate_n       <= 1'b1;
      pins_q.program_strobe_n <= 1'b1;
      pins_q.vpp_prog         <= 1'b0;
      pins_q.id_raise         <= 1'b0;
      pins_q.data_pins        <= uep_pkg::ERASED_BYTE;
      pins_q.data_pins_oe_n   <= 1'b1;
      sel_n_q                 <= '1;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (take) begin
            pins_q.addr           <= pin_addr(i_cmd);
            pins_q.vpp_prog       <= (i_cmd.op == uep_pkg::OP_PROGRAM) ||
                                     (i_cmd.op == uep_pkg::OP_VERIFY);
            pins_q.id_raise       <= (i_cmd.op == uep_pkg::OP_IDENT);
            pins_q.data_pins      <= i_cmd.data;
            pins_q.data_pins_oe_n <= (i_cmd.op != uep_pkg::OP_PROGRAM);
            sel_n_q               <= ~(NUM_DEV'(1) << i_cmd_dev);
          end
        end
        ST_SETUP: begin
          if (tmr_done) begin
            if (cmd_q.op == uep_pkg::OP_PROGRAM) begin
              pins_q.program_strobe_n <= 1'b0;
            end else begin
              pins_q.out_gate_n <= 1'b0;
            end
          end
        end
        ST_STROBE: begin
          if (tmr_done) pins_q.program_strobe_n <= 1'b1;
        end
        ST_ACCESS: begin
          if (tmr_done) pins_q.out_gate_n <= 1'b1;
        end
        ST_HOLD, ST_FLOAT: begin
          if (tmr_done) begin
            sel_n_q               <= '1;
            pins_q.data_pins_oe_n <= 1'b1;
            pins_q.vpp_prog       <= 1'b0;
            pins_q.id_raise       <= 1'b0;
            pins_q.addr           <= '0;
          end
        end
        default: begin
          sel_n_q <= '1;
        end
      endcase
    end
  end

  // Response: captured byte; verify compares with expected byte
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rsp_q       <= '0;
      rsp_valid_q <= 1'b0;
    end else begin
      rsp_valid_q <= (state_q == ST_HOLD || state_q == ST_FLOAT) && tmr_done;
      if (state_q == ST_ACCESS && tmr_done) begin
        rsp_q.data  <= sync2_q;
        rsp_q.match <= (sync2_q == cmd_q.data);
      end
    end
  end

  // Helper: length of the low strobe
  logic [TW-1:0] strobe_len_q;
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      strobe_len_q <= '0;
    end else if (!pins_q.program_strobe_n) begin
      strobe_len_q <= strobe_len_q + TW'(1);
    end else begin
      strobe_len_q <= '0;
    end
  end

  sequence s_gate_open;
    $fell(pins_q.out_gate_n);
  endsequence

  sequence s_gate_closed_later;
    ##GATE_CYC $rose(pins_q.out_gate_n);
  endsequence

  AST_READ_SELECTED: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    !pins_q.out_gate_n |-> (sel_n_q != '1) && pins_q.program_strobe_n)
    else $error("gate low without select or with strobe low");

  AST_NO_CONTENTION: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    !pins_q.data_pins_oe_n |-> pins_q.out_gate_n)
    else $error("host drives data while gate is low");

  AST_IDLE_STANDBY: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    o_cmd_ready |-> (sel_n_q == '1) && pins_q.out_gate_n && pins_q.program_strobe_n)
    else $error("idle but a part is selected");

  AST_PROGRAM_LEVELS: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    !pins_q.program_strobe_n |-> pins_q.vpp_prog && pins_q.out_gate_n
      && !pins_q.data_pins_oe_n && (sel_n_q != '1))
    else $error("strobe low without program conditions");

  AST_PULSE_WIDTH: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    $rose(pins_q.program_strobe_n) |-> strobe_len_q == TW'(PULSE_CYC))
    else $error("program pulse width wrong");

  AST_ONE_SELECT: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    $onehot0(~sel_n_q))
    else $error("more than one part selected");

  AST_VERIFY_SUPPLY: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    !pins_q.out_gate_n && cmd_q.op == uep_pkg::OP_VERIFY |-> pins_q.vpp_prog)
    else $error("verify without program supply");

  AST_ID_ADDR: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    pins_q.id_raise |-> (pins_q.addr & ~(uep_pkg::ADDR_W'(1) << uep_pkg::ID_SEL_BIT)) == '0)
    else $error("identifier mode with stray address bits");

  AST_ID_GATE: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    !pins_q.out_gate_n && cmd_q.op == uep_pkg::OP_IDENT |-> pins_q.id_raise
      && pins_q.program_strobe_n)
    else $error("identifier read without raised trigger");

  AST_ACCESS_TIME: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    s_gate_open |-> s_gate_closed_later)
    else $error("read gate window length wrong");

  AST_RSP_PULSE: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    o_rsp_valid |-> o_cmd_ready ##1 !o_rsp_valid)
    else $error("response not a single pulse");

endmodule : uep_ctrl

// ===== core/uep_timer.sv
// Purpose: Down counter that times each pin phase.
// Assumes: Load value is phase length minus one.
// Notes:   o_done is a level, high while the count sits at zero.
module uep_timer #(
  parameter int W = 17
) (
  input  wire logic         i_clk,
  input  wire logic         i_rst_b,
  input  wire logic         i_load,
  input  wire logic [W-1:0] i_count,
  output logic              o_done
);

  logic [W-1:0] cnt_q;

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      cnt_q <= '0;
    end else if (i_load) begin
      cnt_q <= i_count;
    end else if (cnt_q != '0) begin
      cnt_q <= cnt_q - W'(1);
    end
  end

  // Pure count compare; the sequencer feeds o_done back into i_load
  assign o_done = (cnt_q == '0);

endmodule : uep_timer

// ===== include/uep_pkg.sv
// Purpose: Shared types and timing counts for the UV EPROM pin controller.
// Assumes: 125 MHz system clock; one clock domain.
// Notes:   All pin strobes are active low as on the part.
package uep_pkg;

  localparam int ADDR_W       = 13;
  localparam int DATA_W       = 8;
  // Address line that takes the raised identifier level, and the byte-select line
  localparam int ID_TRIG_BIT  = 9;
  localparam int ID_SEL_BIT   = 0;
  localparam logic [DATA_W-1:0] ERASED_BYTE = 8'hFF;

  // Clock and times, in their own units
  localparam int CLK_PS       = 8000;
  localparam int T_SETUP_NS   = 2000;   // Address, data, select and supply setup
  localparam int T_HOLD_NS    = 2000;   // Data hold after program strobe rises
  localparam int T_ACC_NS     = 250;    // Slowest access, address or select to data
  localparam int T_FLOAT_NS   = 130;    // Gate high to data pins float
  localparam int T_PULSE_US   = 1000;   // Program pulse width
  localparam int SYNC_CYC     = 2;

  // Least times round up to whole cycles
  localparam int SETUP_CYC    = (T_SETUP_NS * 1000 + CLK_PS - 1) / CLK_PS;
  localparam int HOLD_CYC     = (T_HOLD_NS * 1000 + CLK_PS - 1) / CLK_PS;
  localparam int ACC_CYC      = (T_ACC_NS * 1000 + CLK_PS - 1) / CLK_PS;
  localparam int FLOAT_CYC    = (T_FLOAT_NS * 1000 + CLK_PS - 1) / CLK_PS;
  localparam int PULSE_CYC    = (T_PULSE_US * 1000000 + CLK_PS - 1) / CLK_PS;
  localparam int TMR_W        = 17;

  typedef enum logic [1:0] {
    OP_READ,
    OP_PROGRAM,
    OP_VERIFY,
    OP_IDENT
  } uep_op_t;

  typedef struct packed {
    uep_op_t             op;
    logic [ADDR_W-1:0]   addr;
    logic [DATA_W-1:0]   data;   // Byte to program, or expected byte on verify
  } uep_cmd_t;

  typedef struct packed {
    logic [DATA_W-1:0]   data;
    logic                match;
  } uep_rsp_t;

  typedef struct packed {
    logic [ADDR_W-1:0]   addr;
    logic                out_gate_n;
    logic                program_strobe_n;
    logic                vpp_prog;     // Request program-level supply
    logic                id_raise;     // Request raised level on id_trigger_line
    logic [DATA_W-1:0]   data_pins;
    logic                data_pins_oe_n;
  } uep_pins_t;

endpackage : uep_pkg

// ===== verif/tb_top.sv
// Purpose: Self-checking bench for the EPROM pin controller.
// Assumes: Four parts share every pin except select.
// Notes:   Short program pulse keeps the run brief.
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int         ND = 4;
  localparam int         PC = 20;
  localparam logic [7:0] MK = 8'h5A;
  localparam logic [7:0] TY = 8'hC3;
  logic                i_clk = 1'b0;
  logic                i_rst_b = 1'b0;
  logic                i_cmd_valid = 1'b0;
  uep_pkg::uep_cmd_t   i_cmd = '0;
  logic [1:0]          i_cmd_dev = '0;
  logic                o_cmd_ready, o_rsp_valid;
  uep_pkg::uep_rsp_t   o_rsp;
  uep_pkg::uep_pins_t  o_pins;
  logic [ND-1:0]       o_dev_select_n, drv;
  logic [7:0]          i_data_pins, dev_or, dev_q [ND];
  logic [7:0]          last_q = 8'h00;
  int                  bad_count = 0, tests_run = 0, low_cnt = 0;
  int                  ref_mem [int];
  uep_pkg::uep_op_t    cur_op = uep_pkg::OP_READ;
  always #4 i_clk = ~i_clk;

  uep_ctrl #(.NUM_DEV(ND), .PULSE_CYC(PC)) uep_ctrl_inst (
    .i_clk(i_clk), .i_rst_b(i_rst_b), .i_cmd_valid(i_cmd_valid), .i_cmd(i_cmd),
    .i_cmd_dev(i_cmd_dev), .o_cmd_ready(o_cmd_ready), .o_rsp_valid(o_rsp_valid),
    .o_rsp(o_rsp), .o_pins(o_pins), .o_dev_select_n(o_dev_select_n),
    .i_data_pins(i_data_pins));
  for (genvar g = 0; g < ND; g++) begin : g_dev
    // Last part answers at the slowest access time
    uep_dev_model #(.ACC_NS(g == ND-1 ? 250 : 40), .MAKER_CODE(MK), .TYPE_CODE(TY))
      uep_dev_model_inst (.i_sel_n(o_dev_select_n[g]), .i_gate_n(o_pins.out_gate_n),
      .i_pgm_n(o_pins.program_strobe_n), .i_vpp(o_pins.vpp_prog), .i_id(o_pins.id_raise),
      .i_addr(o_pins.addr), .i_data(i_data_pins), .o_drive(drv[g]), .o_data(dev_q[g]));
  end
  always_comb begin
    dev_or = '0;
    for (int k = 0; k < ND; k++) if (drv[k]) dev_or |= dev_q[k];
  end
  // Undriven bus shows a changing pattern, never a held value
  assign i_data_pins = !o_pins.data_pins_oe_n ? o_pins.data_pins : (|drv ? dev_or : ~last_q);
  always @(posedge i_clk) last_q <= i_data_pins;

  task automatic check_byte(string nm, logic [7:0] e, logic [7:0] g);
    tests_run++;
    if (g !== e) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask : check_byte
  task automatic check_bit(string nm, logic e, logic g);
    check_byte(nm, {7'h00, e}, {7'h00, g});
  endtask : check_bit
  task automatic end_sim();
    $display("Counts: %0d checks, %0d mismatches", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : end_sim
  task automatic hang(string nm);
    bad_count++;
    $display("MISMATCH %s expected done seen timeout", nm);
    end_sim();
  endtask : hang
  function automatic logic [31:0] lfsr(logic [31:0] s);
    return (s >> 1) ^ (s[0] ? 32'h8020_0003 : 32'h0000_0000);
  endfunction : lfsr

  // Sampled mid-cycle, away from the edge that launches the pins
  always @(negedge i_clk) begin
    if (i_rst_b) begin
      check_bit("one select", 1'b1, $countones(~o_dev_select_n) <= 1);
      check_bit("one driver", 1'b1, $countones(drv) + !o_pins.data_pins_oe_n <= 1);
      if (!o_pins.program_strobe_n) begin
        check_bit("prog levels", 1'b1, o_pins.out_gate_n && o_pins.vpp_prog
                  && !o_pins.data_pins_oe_n && cur_op == uep_pkg::OP_PROGRAM);
      end else if (low_cnt != 0) begin
        check_bit("pulse width", 1'b1, low_cnt == PC);
      end
      low_cnt <= o_pins.program_strobe_n ? 0 : low_cnt + 1;
      if (!o_pins.out_gate_n) begin
        check_bit("verify supply", cur_op == uep_pkg::OP_VERIFY, o_pins.vpp_prog);
        check_bit("id level", cur_op == uep_pkg::OP_IDENT, o_pins.id_raise);
      end
      if (o_pins.id_raise) check_bit("id addr", 1'b1, ~|o_pins.addr[12:1]);
    end
  end

  // Called at a falling edge; returns in the response cycle
  task automatic do_cmd(uep_pkg::uep_op_t op, int dev, int adr, logic [7:0] dat);
    int n, key, ex;
    key = dev * 8192 + adr;
    ex = ref_mem.exists(key) ? ref_mem[key] : 'hFF;
    if (op == uep_pkg::OP_IDENT) ex = adr[0] ? TY : MK;
    cur_op = op;
    i_cmd_valid = 1'b1;
    i_cmd = '{op, adr[12:0], dat};
    i_cmd_dev = dev[1:0];
    for (n = 0; o_cmd_ready !== 1'b1; n++) begin
      if (n > 50) hang("ready");
      @(negedge i_clk);
    end
    @(negedge i_clk);
    i_cmd_valid = 1'b0;
    for (n = 0; o_rsp_valid !== 1'b1; n++) begin
      if (n > 1000) hang("response");
      @(negedge i_clk);
    end
    if (op == uep_pkg::OP_PROGRAM) begin
      check_bit("prog latency", 1'b1, n == uep_pkg::SETUP_CYC + PC + uep_pkg::HOLD_CYC);
      ref_mem[key] = ex & dat;
    end else begin
      check_bit("latency", 1'b1, n == uep_pkg::SETUP_CYC + uep_pkg::ACC_CYC
                + uep_pkg::SYNC_CYC + uep_pkg::FLOAT_CYC);
      check_byte("read data", ex[7:0], o_rsp.data);
      check_bit("match", ex[7:0] == dat, o_rsp.match);
    end
  endtask : do_cmd

  initial begin
    logic [31:0] s;
    int a, d;
    s = 32'hA3FF;
    repeat (10) @(negedge i_clk);
    check_byte("idle pins", 8'hFF, {o_dev_select_n, o_pins.out_gate_n,
               o_pins.program_strobe_n, ~o_pins.vpp_prog, o_pins.data_pins_oe_n});
    check_bit("idle ready", 1'b1, o_cmd_ready & ~o_pins.id_raise);
    i_rst_b = 1'b1;
    for (d = 0; d < ND; d++) begin
      do_cmd(uep_pkg::OP_READ, d, 0, 8'hFF);
      do_cmd(uep_pkg::OP_READ, d, 8191, 8'h00);
    end
    $display("TEST erased done");
    for (int i = 0; i < 8; i++) begin
      s = lfsr(s);
      a = int'(s[12:0]);
      d = int'(s[14:13]);
      do_cmd(uep_pkg::OP_PROGRAM, d, a, s[23:16]);
      do_cmd(uep_pkg::OP_VERIFY, d, a, s[23:16]);
      do_cmd(uep_pkg::OP_READ, (d + 1) % ND, a, 8'hFF);
      do_cmd(uep_pkg::OP_PROGRAM, d, a, s[31:24]);
      do_cmd(uep_pkg::OP_VERIFY, d, a, ~(s[23:16] & s[31:24]));
      do_cmd(uep_pkg::OP_READ, d, a, s[23:16] & s[31:24]);
    end
    $display("TEST program done");
    for (d = 0; d < ND; d++) begin
      s = lfsr(s);
      do_cmd(uep_pkg::OP_IDENT, d, int'({s[12:1], 1'b0}), MK);
      do_cmd(uep_pkg::OP_IDENT, d, int'({s[24:13], 1'b1}), TY);
    end
    $display("TEST identifier done");
    end_sim();
  end
endmodule : tb_top

// ===== verif/uep_dev_model.sv
// Purpose: Behavioural byte-wide UV EPROM part for the bench.
// Assumes: Supply and raised levels arrive as logic requests.
// Notes:   Data is wrong until the access time has run out.
module uep_dev_model #(
  parameter int         ACC_NS     = 100,
  parameter logic [7:0] MAKER_CODE = 8'h5A,  // Arbitrary value
  parameter logic [7:0] TYPE_CODE  = 8'hC3   // Arbitrary value
) (
  input  wire logic        i_sel_n,
  input  wire logic        i_gate_n,
  input  wire logic        i_pgm_n,
  input  wire logic        i_vpp,
  input  wire logic        i_id,
  input  wire logic [12:0] i_addr,
  input  wire logic [7:0]  i_data,
  output logic             o_drive,
  output logic [7:0]       o_data
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [8192];
  logic [7:0] raw;
  initial foreach (mem[i]) mem[i] = 8'hFF;
  assign o_drive = !i_sel_n && !i_gate_n && i_pgm_n;
  always_comb begin
    raw = i_id ? (i_addr[0] ? TYPE_CODE : MAKER_CODE) : mem[i_addr];
    // Inverted until valid, so a stale capture never matches
    if (!o_drive) raw = ~raw;
  end
  assign #(ACC_NS) o_data = raw;
  always @(negedge i_pgm_n) begin
    if (!i_sel_n && i_gate_n && i_vpp) mem[i_addr] = mem[i_addr] & i_data;
  end
endmodule : uep_dev_model
